// File: include/hrfw_pkg.sv
// Package for the HID report formatter with remote wakeup.
// Assumes a single 125 MHz clock domain.
package hrfw_pkg;
   // ****************************************
   // Report layout
   // ****************************************
   localparam int REPORT_BYTES = 8;
   localparam int KEY_SLOTS = 6;
   localparam int KEY_FIRST_BYTE = 2;
   localparam int HOTKEY_COUNT = 24;
   localparam int HOTKEY_FIRST_BYTE = 1;
   localparam int MODIFIER_BYTE = 0;
   localparam int ID_BYTE = 0;
   localparam logic [7:0] RESERVED_VALUE = 8'h00;
   localparam logic [7:0] EMPTY_SLOT = 8'h00;
   localparam logic [7:0] ID_POWER = 8'h01;
   localparam logic [7:0] ID_HOTKEY = 8'h02;
   localparam logic [7:0] ID_MOUSE = 8'h03;
   localparam logic [3:0] LEN_KEYBOARD = 4'h8;
   localparam logic [3:0] LEN_POWER = 4'h2;
   localparam logic [3:0] LEN_HOTKEY = 4'h5;
   localparam logic [3:0] LEN_MOUSE = 4'h5;
   localparam logic [1:0] EP_KEYBOARD = 2'h1;
   localparam logic [1:0] EP_AUX = 2'h2;
   localparam int LOCK_NUM_BIT = 0;
   localparam int LOCK_CAPS_BIT = 1;
   localparam int LOCK_SCROLL_BIT = 2;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLOCK_MHZ = 125;
   localparam int WAKE_PERIOD_US = 10000;
   localparam int WAKE_PERIOD_CYCLES = WAKE_PERIOD_US * CLOCK_MHZ;
   localparam int WINDOW_US = 2000;
   localparam int WINDOW_CYCLES = WINDOW_US * CLOCK_MHZ;
   localparam int RESUME_US = 10000;
   localparam int RESUME_CYCLES = RESUME_US * CLOCK_MHZ;
   localparam int FIFO_DEPTH = 4;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      HRFW_SRC_KEYBOARD,
      HRFW_SRC_POWER,
      HRFW_SRC_HOTKEY,
      HRFW_SRC_MOUSE
   } hrfw_src_t;

   // Decoded event from the baseband
   typedef struct packed {
      hrfw_src_t src;
      logic [7:0] modifiers;
      logic [KEY_SLOTS*8-1:0] keys;
      logic [2:0] power;
      logic [HOTKEY_COUNT-1:0] hotkeys;
      logic [2:0] buttons;
      logic [7:0] dx;
      logic [7:0] dy;
      logic [7:0] dz;
   } hrfw_event_t;

   // Formatted report toward the USB engine
   typedef struct packed {
      logic [1:0] endpoint;
      logic [3:0] length;
      logic [REPORT_BYTES*8-1:0] data;
   } hrfw_report_t;

   localparam int EVENT_W = $bits(hrfw_event_t);
   localparam int REPORT_W = $bits(hrfw_report_t);
endpackage

// File: logic/hrfw_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/10ps
module hrfw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: logic/hrfw_top.sv
// HID report formatter with remote wakeup sequencer.
// Assumes decoded radio events on the same clock; suspend and the
// baseband interrupt come from other domains and are synchronised here.
//
// Summary of operation
// R1: Keyboard reports carry no identifier; first byte is the modifier byte.
// R2: Each modifier key owns one bit, one while held.
// R3: Byte two reserved zero; bytes three to eight key codes, unused zero.
// R4: Pressed keys fill successive slots from third byte; sent on endpoint 1.
// R5: Power keys use identifier 1; wake key gives 02 in second byte.
// R6: Hot key n sets bit n mod 8 of byte 1+n/8, identifier 2.
// R7: Power and hot key reports go on endpoint 2.
// R8: While suspended, a valid packet triggers resume signalling to host; here only a packet inside the detect window does, one in sleep is dropped.
// R9: During suspend a periodic interrupt wakes the receiver.
// R10: Each wake powers the radio briefly to check for a packet.
// R11: Inside the window the interrupt line serves the baseband again.
// R12: No packet in window: restart the wake cycle and sleep again.
// R13: Transmitter resends unacknowledged packets up to a set limit.
// R14: Detect window should exceed the retransmission interval.
// R15: Shorter wake period suits a small retransmission limit.
// R16: Mouse reports use identifier 3, buttons, then X, Y, Z bytes.
// R17: Host may send a one-byte lock-state output report.
// R18: Wake period and window length are configuration parameters.
`timescale 1ns/10ps
module hrfw_top #(
   parameter int WAKE_PERIOD = hrfw_pkg::WAKE_PERIOD_CYCLES,
   parameter int DETECT_WINDOW = hrfw_pkg::WINDOW_CYCLES,
   parameter int RESUME_LEN = hrfw_pkg::RESUME_CYCLES
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire hrfw_pkg::hrfw_event_t event_i,
   input wire logic event_valid_i,
   output logic event_ready_o,
   output hrfw_pkg::hrfw_report_t report_o,
   output logic report_valid_o,
   input wire logic report_ready_i,
   input wire logic [7:0] lock_report_i,
   input wire logic lock_valid_i,
   output logic [2:0] lock_leds_o,
   input wire logic suspend_i,
   input wire logic irq_i,
   output logic radio_power_o,
   output logic baseband_irq_o,
   output logic resume_o,
   output logic sleep_o
);
   // ****************************************
   // Report packing
   // ****************************************
   function automatic hrfw_pkg::hrfw_report_t pack_report(input hrfw_pkg::hrfw_event_t ev);
      hrfw_pkg::hrfw_report_t r;
      logic [7:0] b [hrfw_pkg::REPORT_BYTES];
      int slot;
      for (int i = 0; i < hrfw_pkg::REPORT_BYTES; i++) begin
         b[i] = 8'h00;
      end
      r = '0;
      slot = 0;
      unique case (ev.src)
         hrfw_pkg::HRFW_SRC_KEYBOARD: begin
            b[hrfw_pkg::MODIFIER_BYTE] = ev.modifiers; // see R1 R2
            b[1] = hrfw_pkg::RESERVED_VALUE; // see R3
            for (int k = 0; k < hrfw_pkg::KEY_SLOTS; k++) begin
               // Compact nonzero codes into successive slots
               if (ev.keys[k*8 +: 8] != hrfw_pkg::EMPTY_SLOT) begin
                  b[hrfw_pkg::KEY_FIRST_BYTE + slot] = ev.keys[k*8 +: 8]; // see R3 R4
                  slot = slot + 1;
               end
            end
            r.endpoint = hrfw_pkg::EP_KEYBOARD; // see R4
            r.length = hrfw_pkg::LEN_KEYBOARD;
         end
         hrfw_pkg::HRFW_SRC_POWER: begin
            b[hrfw_pkg::ID_BYTE] = hrfw_pkg::ID_POWER; // see R5
            b[1] = {5'h00, ev.power}; // see R5
            r.endpoint = hrfw_pkg::EP_AUX; // see R7
            r.length = hrfw_pkg::LEN_POWER;
         end
         hrfw_pkg::HRFW_SRC_HOTKEY: begin
            b[hrfw_pkg::ID_BYTE] = hrfw_pkg::ID_HOTKEY; // see R6
            for (int n = 0; n < hrfw_pkg::HOTKEY_COUNT; n++) begin
               if (ev.hotkeys[n]) begin
                  b[hrfw_pkg::HOTKEY_FIRST_BYTE + n / 8][n % 8] = 1'b1; // see R6
               end
            end
            r.endpoint = hrfw_pkg::EP_AUX; // see R7
            r.length = hrfw_pkg::LEN_HOTKEY;
         end
         hrfw_pkg::HRFW_SRC_MOUSE: begin
            b[hrfw_pkg::ID_BYTE] = hrfw_pkg::ID_MOUSE; // see R16
            b[1] = {5'h00, ev.buttons};
            b[2] = ev.dx;
            b[3] = ev.dy;
            b[4] = ev.dz;
            r.endpoint = hrfw_pkg::EP_AUX;
            r.length = hrfw_pkg::LEN_MOUSE;
         end
      endcase
      for (int i = 0; i < hrfw_pkg::REPORT_BYTES; i++) begin
         r.data[i*8 +: 8] = b[i];
      end
      return r;
   endfunction

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [1:0] suspend_sync;
   logic [1:0] irq_sync;
   logic suspended;
   logic irq_seen;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         suspend_sync <= 2'h0;
         irq_sync <= 2'h0;
      end else begin
         suspend_sync <= {suspend_sync[0], suspend_i};
         irq_sync <= {irq_sync[0], irq_i};
      end
   end
   assign suspended = suspend_sync[1];
   assign irq_seen = irq_sync[1];

   // ****************************************
   // Formatting into FIFO
   // ****************************************
   hrfw_pkg::hrfw_report_t packed_report;
   logic fifo_in_ready;
   hrfw_pkg::hrfw_report_t fifo_out;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic accept;

   assign packed_report = pack_report(event_i);
   // Events are consumed only while the bus is awake
   assign accept = event_valid_i && fifo_in_ready && !suspended;
   assign fifo_out_ready = !report_valid_o || report_ready_i;

   hrfw_fifo #(
      .WIDTH(hrfw_pkg::REPORT_W),
      .DEPTH(hrfw_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .in_data_i(packed_report),
      .in_valid_i(event_valid_i && !suspended),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready)
   );

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         event_ready_o <= 1'b0;
      end else begin
         // Acknowledge: high for one cycle after an event was taken
         event_ready_o <= accept;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         report_o <= '0;
         report_valid_o <= 1'b0;
      end else if (fifo_out_ready) begin
         report_o <= fifo_out;
         report_valid_o <= fifo_out_valid;
      end
   end

   // ****************************************
   // Lock state from host
   // ****************************************
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lock_leds_o <= 3'h0;
      end else if (lock_valid_i) begin
         lock_leds_o <= {lock_report_i[hrfw_pkg::LOCK_SCROLL_BIT],
                         lock_report_i[hrfw_pkg::LOCK_CAPS_BIT],
                         lock_report_i[hrfw_pkg::LOCK_NUM_BIT]};
      end
   end

   // ****************************************
   // Remote wakeup sequencer
   // ****************************************
   typedef enum logic [2:0] {
      HRFW_AWAKE,
      HRFW_SLEEP,
      HRFW_DETECT,
      HRFW_RESUME
   } hrfw_state_t;

   hrfw_state_t state;
   hrfw_state_t next_state;
   logic wake_pulse;
   logic window_end;
   logic restart;
   logic [31:0] resume_cnt;

   hrfw_wake_timer #(
      .PERIOD(WAKE_PERIOD), // see R15 R18
      .WINDOW(DETECT_WINDOW)
   ) u_timer (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .run_i(state == HRFW_SLEEP || state == HRFW_DETECT), // see R9 R18
      .restart_i(restart),
      .wake_o(wake_pulse),
      .window_end_o(window_end)
   );

   // Restart the cycle when the window ends empty
   assign restart = (state == HRFW_DETECT) && window_end && !event_valid_i; // see R12

   always_comb begin
      next_state = state;
      unique case (state)
         HRFW_AWAKE: if (suspended) next_state = HRFW_SLEEP;
         HRFW_SLEEP: begin
            if (!suspended) next_state = HRFW_AWAKE;
            else if (wake_pulse) next_state = HRFW_DETECT; // see R9 R10
         end
         HRFW_DETECT: begin
            if (!suspended) next_state = HRFW_AWAKE;
            else if (event_valid_i) next_state = HRFW_RESUME; // see R8
            else if (window_end) next_state = HRFW_SLEEP; // see R12 R14
         end
         HRFW_RESUME: begin
            if (!suspended || resume_cnt == 32'(RESUME_LEN - 1)) next_state = HRFW_AWAKE;
         end
         default: next_state = HRFW_AWAKE;
      endcase
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= HRFW_AWAKE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         resume_cnt <= '0;
      end else if (state == HRFW_RESUME) begin
         resume_cnt <= resume_cnt + 32'h1;
      end else begin
         resume_cnt <= '0;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         radio_power_o <= 1'b1;
         baseband_irq_o <= 1'b0;
         resume_o <= 1'b0;
         sleep_o <= 1'b0;
      end else begin
         radio_power_o <= (next_state != HRFW_SLEEP); // see R10
         // Interrupt routed to baseband except while asleep
         baseband_irq_o <= irq_seen && (next_state != HRFW_SLEEP); // see R11
         resume_o <= (next_state == HRFW_RESUME); // see R8
         sleep_o <= (next_state == HRFW_SLEEP); // see R12
      end
   end
endmodule

// File: logic/hrfw_wake_timer.sv
// Periodic wake source for suspend: interval and detect window counter.
// Assumes one clock; stands in for the RC wake oscillator.
`timescale 1ns/10ps
module hrfw_wake_timer #(
   parameter int PERIOD = 8,
   parameter int WINDOW = 4
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic run_i,
   input wire logic restart_i,
   output logic wake_o,
   output logic window_end_o
);
   logic [31:0] period_cnt;
   logic [31:0] window_cnt;
   logic in_window;

   // ****************************************
   // Interval and window
   // ****************************************
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         period_cnt <= '0;
         wake_o <= 1'b0;
      end else begin
         wake_o <= 1'b0;
         if (!run_i || restart_i || in_window) begin
            period_cnt <= '0;
         end else if (period_cnt == 32'(PERIOD - 1)) begin
            period_cnt <= '0;
            wake_o <= 1'b1;
         end else begin
            period_cnt <= period_cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         window_cnt <= '0;
         in_window <= 1'b0;
         window_end_o <= 1'b0;
      end else begin
         window_end_o <= 1'b0;
         if (!run_i || restart_i) begin
            in_window <= 1'b0;
            window_cnt <= '0;
         end else if (wake_o) begin
            in_window <= 1'b1;
            window_cnt <= '0;
         end else if (in_window) begin
            if (window_cnt == 32'(WINDOW - 1)) begin
               in_window <= 1'b0;
               window_end_o <= 1'b1;
            end else begin
               window_cnt <= window_cnt + 32'h1;
            end
         end
      end
   end
endmodule

// File: tb/hrfw_checker.sv
// Port checker for the report formatter with wakeup.
// Assumes binding onto hrfw_top, one clock domain.
`timescale 1ns/10ps
module hrfw_checker #(
   parameter int WAKE_PERIOD = 20,
   parameter int RESUME_LEN = 5
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire hrfw_pkg::hrfw_report_t report_o,
   input wire logic report_valid_o,
   input wire logic report_ready_i,
   input wire logic [7:0] lock_report_i,
   input wire logic lock_valid_i,
   input wire logic [2:0] lock_leds_o,
   input wire logic suspend_i,
   input wire logic radio_power_o,
   input wire logic baseband_irq_o,
   input wire logic resume_o,
   input wire logic sleep_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   int sleep_cnt;
   int res_cnt;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sleep_cnt <= 0;
      end else begin
         sleep_cnt <= sleep_o ? sleep_cnt + 1 : 0;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         res_cnt <= 0;
      end else begin
         res_cnt <= resume_o ? res_cnt + 1 : 0;
      end
   end

   AST_HOLD: assert property (report_valid_o && !report_ready_i |=> report_valid_o && $stable(report_o))
      else $error("report changed before it was taken");
   AST_KBD: assert property (report_valid_o && report_o.endpoint == hrfw_pkg::EP_KEYBOARD |->
      report_o.length == hrfw_pkg::LEN_KEYBOARD && report_o.data[15:8] == hrfw_pkg::RESERVED_VALUE)
      else $error("keyboard report layout wrong");
   AST_AUX_EP: assert property (report_valid_o && report_o.endpoint != hrfw_pkg::EP_KEYBOARD |->
      report_o.endpoint == hrfw_pkg::EP_AUX) else $error("report on unknown endpoint");
   AST_POWER: assert property (report_valid_o && report_o.endpoint == hrfw_pkg::EP_AUX &&
      report_o.data[7:0] == hrfw_pkg::ID_POWER |-> report_o.length == hrfw_pkg::LEN_POWER)
      else $error("power report length wrong");
   AST_HOTKEY: assert property (report_valid_o && report_o.endpoint == hrfw_pkg::EP_AUX &&
      report_o.data[7:0] == hrfw_pkg::ID_HOTKEY |-> report_o.length == hrfw_pkg::LEN_HOTKEY &&
      report_o.data[39:32] == 8'h00) else $error("hot key report layout wrong");
   AST_SLEEP_RADIO: assert property (sleep_o |-> !radio_power_o && !baseband_irq_o)
      else $error("radio or irq active while asleep");
   AST_MOUSE: assert property (report_valid_o && report_o.endpoint == hrfw_pkg::EP_AUX &&
      report_o.data[7:0] == hrfw_pkg::ID_MOUSE |-> report_o.length == hrfw_pkg::LEN_MOUSE)
      else $error("mouse report length wrong");
   AST_AWAKE: assert property (!suspend_i [*4] |-> !sleep_o)
      else $error("asleep while bus not suspended");
   AST_PERIOD: assert property (sleep_o |-> sleep_cnt <= WAKE_PERIOD)
      else $error("sleep lasted past wake period");
   AST_RESUME: assert property (resume_o |-> res_cnt <= RESUME_LEN)
      else $error("resume signalling too long");
   AST_LOCK: assert property (lock_valid_i |=> lock_leds_o == $past(lock_report_i[2:0]))
      else $error("lock indicators not updated");
endmodule

bind hrfw_top hrfw_checker #(.WAKE_PERIOD(WAKE_PERIOD), .RESUME_LEN(RESUME_LEN)) i_checker (
   .clock_i(clock_i), .rstn_i(rstn_i), .report_o(report_o), .report_valid_o(report_valid_o),
   .report_ready_i(report_ready_i), .lock_report_i(lock_report_i), .lock_valid_i(lock_valid_i),
   .lock_leds_o(lock_leds_o), .suspend_i(suspend_i), .radio_power_o(radio_power_o),
   .baseband_irq_o(baseband_irq_o), .resume_o(resume_o), .sleep_o(sleep_o));

// File: tb/hrfw_host_model.sv
// Host side of the report stream: takes reports, may stall.
// Assumes the formatter holds reports until taken.
`timescale 1ns/10ps
module hrfw_host_model (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire hrfw_pkg::hrfw_report_t report_i,
   input wire logic report_valid_i,
   input wire logic stall_i,
   output logic report_ready_o,
   output logic got_o,
   output hrfw_pkg::hrfw_report_t got_report_o
);
   assign report_ready_o = !stall_i;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         got_o <= 1'b0;
         got_report_o <= '0;
      end else begin
         got_o <= report_valid_i && report_ready_o;
         if (report_valid_i && report_ready_o) begin
            got_report_o <= report_i;
         end
      end
   end
endmodule

// File: tb/test_hid_report_formatter_wakeup.sv
// Self-checking bench for the report formatter with wakeup.
// Assumes short wake counts set through parameters.
`timescale 1ns/10ps
module test_hid_report_formatter_wakeup;
   typedef struct {hrfw_pkg::hrfw_event_t ev; hrfw_pkg::hrfw_report_t rep;} hrfw_row_t;
   logic clock_i, rstn_i, event_valid_i, report_ready_i, lock_valid_i, suspend_i, irq_i, stall, got, ack;
   logic [7:0] lock_report_i;
   logic report_valid_o, radio_power_o, baseband_irq_o, resume_o, sleep_o;
   logic [2:0] lock_leds_o;
   hrfw_pkg::hrfw_event_t event_i;
   hrfw_pkg::hrfw_report_t report_o, got_rep;
   hrfw_row_t rows [5];
   int failures, n_checks;

   hrfw_top #(.WAKE_PERIOD(20), .DETECT_WINDOW(8), .RESUME_LEN(5)) i_dut (.clock_i(clock_i),
      .rstn_i(rstn_i), .event_i(event_i), .event_valid_i(event_valid_i), .event_ready_o(ack),
      .report_o(report_o), .report_valid_o(report_valid_o), .report_ready_i(report_ready_i),
      .lock_report_i(lock_report_i), .lock_valid_i(lock_valid_i), .lock_leds_o(lock_leds_o),
      .suspend_i(suspend_i), .irq_i(irq_i), .radio_power_o(radio_power_o),
      .baseband_irq_o(baseband_irq_o), .resume_o(resume_o), .sleep_o(sleep_o));
   hrfw_host_model i_host (.clock_i(clock_i), .rstn_i(rstn_i), .report_i(report_o),
      .report_valid_i(report_valid_o), .stall_i(stall), .report_ready_o(report_ready_i),
      .got_o(got), .got_report_o(got_rep));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   task complete_run();
      if (failures == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task check(input logic [69:0] seen, input logic [69:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task cmp_rep(input hrfw_pkg::hrfw_report_t s, input hrfw_pkg::hrfw_report_t e);
      logic [63:0] m;
      m = (64'h1 << (8 * e.length)) - 64'h1;
      check({s.endpoint, s.length, s.data & m}, {e.endpoint, e.length, e.data & m});
   endtask

   // ****************************************
   // Bounded waits: 0 sleep, 1 resume, 2 report taken
   // ****************************************
   task wait_sig(input int sel, input logic lvl);
      logic v;
      for (int k = 0; k < 60; k++) begin
         @(negedge clock_i);
         v = (sel == 0) ? sleep_o : (sel == 1) ? resume_o : got;
         if (v === lvl) begin
            return;
         end
      end
      failures++;
      complete_run();
   endtask

   task push(input hrfw_pkg::hrfw_event_t ev);
      @(negedge clock_i);
      event_i = ev;
      event_valid_i = 1'b1;
      @(negedge clock_i);
      event_valid_i = 1'b0;
   endtask

   initial begin
      rows[0] = '{'{hrfw_pkg::HRFW_SRC_KEYBOARD, 8'h01, 48'h04, 3'h0, 24'h0, 3'h0, 8'h00, 8'h00, 8'h00},
                  '{2'h1, 4'h8, 64'h0000000000040001}};
      rows[1] = '{'{hrfw_pkg::HRFW_SRC_KEYBOARD, 8'h41, 48'h050004, 3'h0, 24'h0, 3'h0, 8'h00, 8'h00, 8'h00},
                  '{2'h1, 4'h8, 64'h0000000005040041}};
      rows[2] = '{'{hrfw_pkg::HRFW_SRC_POWER, 8'h00, 48'h0, 3'h2, 24'h0, 3'h0, 8'h00, 8'h00, 8'h00},
                  '{2'h2, 4'h2, 64'h0201}};
      rows[3] = '{'{hrfw_pkg::HRFW_SRC_HOTKEY, 8'h00, 48'h0, 3'h0, 24'h020001, 3'h0, 8'h00, 8'h00, 8'h00},
                  '{2'h2, 4'h5, 64'h0002000102}};
      rows[4] = '{'{hrfw_pkg::HRFW_SRC_MOUSE, 8'h00, 48'h0, 3'h0, 24'h0, 3'h5, 8'h10, 8'hF0, 8'h01},
                  '{2'h2, 4'h5, 64'h01F0100503}};
      failures = 0;
      n_checks = 0;
      rstn_i = 1'b0;
      event_i = '0;
      {event_valid_i, lock_valid_i, suspend_i, irq_i, stall} = 5'h00;
      lock_report_i = 8'h00;
      repeat (20) @(negedge clock_i);
      check({report_valid_o, radio_power_o}, 2'h1);
      rstn_i = 1'b1;
      for (int i = 0; i < 5; i++) begin
         push(rows[i].ev);
         check(ack, 1'b1);
         wait_sig(2, 1'b1);
         cmp_rep(got_rep, rows[i].rep);
      end
      // Host output report with spare bits set
      @(negedge clock_i);
      lock_report_i = 8'hFD;
      lock_valid_i = 1'b1;
      @(negedge clock_i);
      lock_valid_i = 1'b0;
      @(negedge clock_i);
      check(lock_leds_o, 3'h5);
      // Burst against a stalled host: five held, sixth refused
      stall = 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(negedge clock_i);
         event_i = rows[i % 5].ev;
         event_valid_i = 1'b1;
      end
      @(negedge clock_i);
      event_valid_i = 1'b0;
      repeat (3) @(negedge clock_i);
      stall = 1'b0;
      for (int i = 0; i < 5; i++) begin
         wait_sig(2, 1'b1);
         cmp_rep(got_rep, rows[i].rep);
      end
      repeat (10) @(negedge clock_i);
      check(report_valid_o, 1'b0);
      // Suspend: sleep, periodic wake, window end, detection
      suspend_i = 1'b1;
      wait_sig(0, 1'b1);
      check(radio_power_o, 1'b0);
      push(rows[0].ev);
      check(ack, 1'b0);
      wait_sig(0, 1'b0);
      check(radio_power_o, 1'b1);
      irq_i = 1'b1;
      repeat (3) @(negedge clock_i);
      check(baseband_irq_o, 1'b1);
      irq_i = 1'b0;
      wait_sig(0, 1'b1);
      check({sleep_o, resume_o}, 2'h2);
      wait_sig(0, 1'b0);
      push(rows[0].ev);
      wait_sig(1, 1'b1);
      check(resume_o, 1'b1);
      suspend_i = 1'b0;
      repeat (10) @(negedge clock_i);
      check({resume_o, sleep_o, radio_power_o}, 3'h1);
      complete_run();
   end
endmodule
